// >>> logic/hrx_defines.vh
// Constants for the receive HDLC queue controller: register indices,
// field positions, reset values, packet status codes and deframer figures.
// Included by the controller; holds definitions only.
`ifndef HRX_DEFINES_VH
`define HRX_DEFINES_VH

// Register indices; byte address is four times the index
`define HRX_IDX_CTRL     8'hb0
`define HRX_IDX_LIVE     8'hb4
`define HRX_IDX_LATCH    8'hb6
`define HRX_IDX_IRQEN    8'hb8
`define HRX_IDX_FIFO     8'hbc

// Control fields
`define HRX_CTRL_FLUSH   0
`define HRX_CTRL_CSOFF   1
`define HRX_CTRL_INV     2
`define HRX_CTRL_SWAP    3
`define HRX_CTRL_THR_LO  8
`define HRX_CTRL_THR_HI  12
`define HRX_THR_RESET    5'h08

// Latched status and enable fields
`define HRX_LAT_AVAIL    0
`define HRX_LAT_FULL     2
`define HRX_LAT_PS       3
`define HRX_LAT_PE       4
`define HRX_LAT_OVF      7

// Packet status codes stored with each byte
`define HRX_ST_MID       3'h0
`define HRX_ST_START     3'h1
`define HRX_ST_GOOD      3'h4
`define HRX_ST_FCSERR    3'h5
`define HRX_ST_NONINT    3'h6
`define HRX_ST_ABORT     3'h7

// Deframer figures
`define HRX_ONES_STUFF   3'h5
`define HRX_ONES_FLAG    3'h6
`define HRX_ONES_MAX     3'h7
`define HRX_CRC_INIT     16'hffff
`define HRX_CRC_POLY     16'h8408
`define HRX_CRC_RESIDUE  16'hf0b8
`define HRX_PWRUP_CYCLES 16'h0010

`endif

// >>> logic/hrx_receiver.v
// Receive HDLC controller for one port: deframer, 256-entry receive queue,
// live, latched and enable registers, and an AHB-Lite slave for software.
// Assumes the framer delivers one bit per strobe on mclk, and that the
// global per-port summary enable is a level on mclk.
`timescale 1ns/10ps
`include "hrx_defines.vh"

module hrx_receiver #(
	parameter        AW           = 8,                  // Queue address width
	parameter [15:0] PWRUP_CYCLES = `HRX_PWRUP_CYCLES   // Memory power-up cycles
) (
	input  wire        mclk,             // System clock
	input  wire        rstn,             // Asynchronous reset, active low
	input  wire        hsel,             // AHB slave select
	input  wire [31:0] haddr,            // AHB address
	input  wire [1:0]  htrans,           // AHB transfer type
	input  wire        hwrite,           // AHB write
	input  wire [2:0]  hsize,            // AHB size
	input  wire [31:0] hwdata,           // AHB write data
	input  wire        hready,           // AHB bus ready
	output reg         hreadyout,        // AHB slave ready
	output reg         hresp,            // AHB response, always OKAY
	output reg  [31:0] hrdata,           // AHB read data
	input  wire        rxBitIn,          // Serial data from framer
	input  wire        rxBitStb,         // One pulse per serial bit
	input  wire        portSummaryIrqEn, // Port summary interrupt enable
	output reg         rxIrq             // Interrupt request, active high
);
	localparam DEPTH = 1 << AW;
	localparam [AW:0] FULLCNT = {1'b1, {AW{1'b0}}};
	// Control and enables
	reg [4:0]    availThreshold;
	reg          bitOrderSwapEn;
	reg          invertInEn;
	reg          checksumOff;
	reg          queueFlush;
	reg          overflowIrqEn;
	reg          pktEndIrqEn;
	reg          pktStartIrqEn;
	reg          fullIrqEn;
	reg          availIrqEn;
	// Status
	reg          overflowLatch;
	reg          pktEndLatch;
	reg          pktStartLatch;
	reg          fullLatch;
	reg          availLatch;
	reg          queueFull;
	reg          queueEmpty;
	reg          dataAvail;
	// Deframer
	reg [2:0]    onesRun;
	reg          hunting;
	reg [2:0]    bitCnt;
	reg [7:0]    acc;
	reg [15:0]   crc;
	reg [15:0]   crcAtByte;
	reg [7:0]    hold0;
	reg [7:0]    hold1;
	reg [7:0]    hold2;
	reg [1:0]    nHold;
	reg          startPend;
	reg [15:0]   pwrCnt;
	// Queue
	reg [10:0]   mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr;
	reg [AW-1:0] rdPtr;
	reg [AW:0]   count;
	// Bus data phase
	reg          wrPend;
	reg [7:0]    wrIdx;
	reg [1:0]    wrBe;
	// Bit front end
	wire        bitIn   = rxBitIn ^ invertInEn;
	wire        powered = (pwrCnt == PWRUP_CYCLES);
	wire        bitStb  = rxBitStb & ~queueFlush & powered;
	wire        isStuff = ~bitIn & (onesRun == `HRX_ONES_STUFF);
	wire        isFlag  = ~bitIn & (onesRun == `HRX_ONES_FLAG);
	wire        isAbort = bitIn & (onesRun == `HRX_ONES_FLAG);
	wire        push    = bitStb & ~hunting & ~isStuff & ~isFlag & ~isAbort;
	wire [7:0]  nextAcc = bitOrderSwapEn ? {acc[6:0], bitIn}
	                                     : {bitIn, acc[7:1]};
	wire        crcFb   = crc[0] ^ bitIn;
	wire [15:0] next_crc = {1'b0, crc[15:1]} ^ (crcFb ? `HRX_CRC_POLY : 16'h0000);
	wire        byteDone = push & (bitCnt == 3'h7);
	// The last data byte, and the two FCS bytes unless checksumOff, stay held so the end can be tagged
	wire [1:0]  holdDepth  = checksumOff ? 2'h1 : 2'h3;
	wire        shiftOut   = byteDone & (nHold >= holdDepth);
	wire        frameEnd   = bitStb & ~hunting & isFlag & (nHold != 2'h0);
	wire        frameAbort = bitStb & ~hunting & isAbort & (nHold != 2'h0);
	reg [2:0] endCode;
	always @*
	begin
		// Flag bits leave 7 pushes past the last whole byte
		if (bitCnt != 3'h7 || nHold != holdDepth)
			endCode = `HRX_ST_NONINT;
		else if (checksumOff || crcAtByte == `HRX_CRC_RESIDUE)
			endCode = `HRX_ST_GOOD;
		else
			endCode = `HRX_ST_FCSERR;
	end
	// Queue write side
	wire       fWrReq  = shiftOut | frameEnd | frameAbort;
	wire [2:0] fWrStat = frameAbort ? `HRX_ST_ABORT :
	                     frameEnd   ? endCode :
	                     startPend  ? `HRX_ST_START : `HRX_ST_MID;
	wire       fWr     = fWrReq & ~queueFull;
	wire       ovfEvt  = fWrReq & queueFull;
	// Bus address phase
	wire       accept = hsel & htrans[1] & hready;
	wire [7:0] aIdx   = haddr[9:2];
	wire       aBe0   = (hsize == 3'h0) ? (haddr[1:0] == 2'h0) : ~haddr[1];
	wire       aBe1   = (hsize == 3'h0) ? (haddr[1:0] == 2'h1) : ~haddr[1];
	// A lower-byte-only read leaves the head in place
	wire       pop    = accept & ~hwrite & (aIdx == `HRX_IDX_FIFO) & aBe1
	                    & ~queueEmpty & ~queueFlush;
	wire [10:0] head  = mem[rdPtr];
	wire [AW:0] next_count = queueFlush ? {(AW+1){1'b0}} :
	                         count + {{AW{1'b0}}, fWr} - {{AW{1'b0}}, pop};
	wire next_full  = (next_count == FULLCNT);
	wire next_empty = (next_count == {(AW+1){1'b0}});
	wire next_avail = ~queueFlush &
	                  (next_count >= {{(AW-7){1'b0}}, availThreshold, 3'h0});
	// Data phase writes
	wire wCtrl  = wrPend & (wrIdx == `HRX_IDX_CTRL);
	wire wLatch = wrPend & (wrIdx == `HRX_IDX_LATCH) & wrBe[0];
	wire wIrqEn = wrPend & (wrIdx == `HRX_IDX_IRQEN) & wrBe[0];
	reg [15:0] rdVal;
	always @*
	begin
		case (aIdx)
		`HRX_IDX_CTRL:
			rdVal = {3'h0, availThreshold, 4'h0,
			         bitOrderSwapEn, invertInEn, checksumOff, queueFlush};
		`HRX_IDX_LIVE:
			rdVal = {13'h0000, queueFull, queueEmpty, dataAvail};
		`HRX_IDX_LATCH:
			rdVal = {8'h00, overflowLatch, 2'h0, pktEndLatch, pktStartLatch,
			         fullLatch, 1'b0, availLatch};
		`HRX_IDX_IRQEN:
			rdVal = {8'h00, overflowIrqEn, 2'h0, pktEndIrqEn, pktStartIrqEn,
			         fullIrqEn, 1'b0, availIrqEn};
		`HRX_IDX_FIFO:
			// Unwritten entries stay unknown, so an empty queue reads zero
			rdVal = queueEmpty ? 16'h0000
			                   : {head[7:0], 4'h0, head[10:8], 1'b1};
		default:
			rdVal = 16'h0000;
		endcase
	end

	// Bus slave: zero wait states, read data registered at the address edge
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0000_0000;
			wrPend    <= 1'b0;
			wrIdx     <= 8'h00;
			wrBe      <= 2'h0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wrPend    <= accept & hwrite;
			if (accept)
			begin
				wrIdx <= aIdx;
				wrBe  <= {aBe1, aBe0};
			end
			if (accept & ~hwrite)
				hrdata <= {16'h0000, rdVal};
		end
	end

	// Control and enable registers
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			availThreshold <= `HRX_THR_RESET;
			bitOrderSwapEn <= 1'b0;
			invertInEn     <= 1'b0;
			checksumOff    <= 1'b0;
			queueFlush     <= 1'b0;
			overflowIrqEn  <= 1'b0;
			pktEndIrqEn    <= 1'b0;
			pktStartIrqEn  <= 1'b0;
			fullIrqEn      <= 1'b0;
			availIrqEn     <= 1'b0;
		end
		else
		begin
			if (wCtrl & wrBe[0])
			begin
				bitOrderSwapEn <= hwdata[`HRX_CTRL_SWAP];
				invertInEn     <= hwdata[`HRX_CTRL_INV];
				checksumOff    <= hwdata[`HRX_CTRL_CSOFF];
				queueFlush     <= hwdata[`HRX_CTRL_FLUSH];
			end
			if (wCtrl & wrBe[1])
				availThreshold <= hwdata[`HRX_CTRL_THR_HI:`HRX_CTRL_THR_LO];
			if (wIrqEn)
			begin
				overflowIrqEn <= hwdata[`HRX_LAT_OVF];
				pktEndIrqEn   <= hwdata[`HRX_LAT_PE];
				pktStartIrqEn <= hwdata[`HRX_LAT_PS];
				fullIrqEn     <= hwdata[`HRX_LAT_FULL];
				availIrqEn    <= hwdata[`HRX_LAT_AVAIL];
			end
		end
	end

	// Live and latched status; a set in the clearing cycle wins
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			queueFull     <= 1'b0;
			queueEmpty    <= 1'b1;
			dataAvail     <= 1'b0;
			overflowLatch <= 1'b0;
			pktEndLatch   <= 1'b0;
			pktStartLatch <= 1'b0;
			fullLatch     <= 1'b0;
			availLatch    <= 1'b0;
			rxIrq         <= 1'b0;
		end
		else
		begin
			queueFull  <= next_full;
			queueEmpty <= next_empty;
			dataAvail  <= next_avail;
			overflowLatch <= ovfEvt |
			                 (overflowLatch & ~(wLatch & hwdata[`HRX_LAT_OVF]));
			pktEndLatch   <= (fWr & fWrStat[2]) |
			                 (pktEndLatch & ~(wLatch & hwdata[`HRX_LAT_PE]));
			pktStartLatch <= (fWr & (fWrStat == `HRX_ST_START)) |
			                 (pktStartLatch & ~(wLatch & hwdata[`HRX_LAT_PS]));
			fullLatch     <= (next_full & ~queueFull) |
			                 (fullLatch & ~(wLatch & hwdata[`HRX_LAT_FULL]));
			availLatch    <= (next_avail & ~dataAvail) |
			                 (availLatch & ~(wLatch & hwdata[`HRX_LAT_AVAIL]));
			rxIrq <= portSummaryIrqEn &
			         ((overflowLatch & overflowIrqEn) |
			          (pktEndLatch & pktEndIrqEn) |
			          (pktStartLatch & pktStartIrqEn) |
			          (fullLatch & fullIrqEn) |
			          (availLatch & availIrqEn));
		end
	end

	// Queue storage and pointers
	always @(posedge mclk)
	begin
		if (fWr)
			mem[wrPtr] <= {fWrStat, hold0};
	end

	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			wrPtr <= {AW{1'b0}};
			rdPtr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end
		else
		begin
			count <= next_count;
			if (queueFlush)
			begin
				wrPtr <= {AW{1'b0}};
				rdPtr <= {AW{1'b0}};
			end
			else
			begin
				if (fWr)
					wrPtr <= wrPtr + {{(AW-1){1'b0}}, 1'b1};
				if (pop)
					rdPtr <= rdPtr + {{(AW-1){1'b0}}, 1'b1};
			end
		end
	end

	// Memory power-up after flush; bits are ignored until it completes
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			pwrCnt <= 16'h0000;
		else if (queueFlush)
			pwrCnt <= 16'h0000;
		else if (!powered)
			pwrCnt <= pwrCnt + 16'h0001;
	end

	// Deframer: flag hunt, zero removal, abort, byte assembly, FCS
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			onesRun   <= 3'h0;
			hunting   <= 1'b1;
			bitCnt    <= 3'h0;
			acc       <= 8'h00;
			crc       <= `HRX_CRC_INIT;
			crcAtByte <= `HRX_CRC_INIT;
			hold0     <= 8'h00;
			hold1     <= 8'h00;
			hold2     <= 8'h00;
			nHold     <= 2'h0;
			startPend <= 1'b1;
		end
		else if (queueFlush)
		begin
			// Drop any frame in progress; resume only on a fresh flag
			onesRun   <= 3'h0;
			hunting   <= 1'b1;
			bitCnt    <= 3'h0;
			nHold     <= 2'h0;
			startPend <= 1'b1;
		end
		else if (bitStb)
		begin
			if (bitIn)
				onesRun <= (onesRun == `HRX_ONES_MAX) ? `HRX_ONES_MAX
				                                      : onesRun + 3'h1;
			else
				onesRun <= 3'h0;
			if (isFlag)
			begin
				hunting   <= 1'b0;
				bitCnt    <= 3'h0;
				crc       <= `HRX_CRC_INIT;
				nHold     <= 2'h0;
				startPend <= 1'b1;
			end
			else if (isAbort)
			begin
				hunting <= 1'b1;
				nHold   <= 2'h0;
			end
			else if (push)
			begin
				acc    <= nextAcc;
				bitCnt <= bitCnt + 3'h1;
				crc    <= next_crc;
				if (byteDone)
				begin
					crcAtByte <= next_crc;
					if (shiftOut)
					begin
						hold0     <= checksumOff ? nextAcc : hold1;
						hold1     <= hold2;
						hold2     <= nextAcc;
						startPend <= 1'b0;
					end
					else
					begin
						case (nHold)
						2'h0:
							hold0 <= nextAcc;
						2'h1:
							hold1 <= nextAcc;
						default:
							hold2 <= nextAcc;
						endcase
						nHold <= nHold + 2'h1;
					end
				end
			end
		end
	end

endmodule // hrx_receiver

// >>> verif/hrx_receiver_asserts.sv
// Port checker for the receive HDLC controller.
// Assumes one clock, mclk, and reset rstn, active low.
`timescale 1ns/10ps
module hrx_receiver_asserts (
	input wire        mclk,             // Clock
	input wire        rstn,             // Reset
	input wire        hsel,             // Select
	input wire [31:0] haddr,            // Address
	input wire [1:0]  htrans,           // Type
	input wire        hwrite,           // Write
	input wire [2:0]  hsize,            // Size
	input wire [31:0] hwdata,           // Wdata
	input wire        hready,           // Ready
	input wire        hreadyout,        // Ready out
	input wire        hresp,            // Response
	input wire [31:0] hrdata,           // Rdata
	input wire        rxBitIn,          // Bit
	input wire        rxBitStb,         // Strobe
	input wire        portSummaryIrqEn, // Port enable
	input wire        rxIrq             // Interrupt
);
	wire       rdTaken = hsel && htrans[1] && hready && !hwrite;
	wire [7:0] idx     = haddr[9:2];
	wire       mapped  = idx == 8'hb0 || idx == 8'hb4 || idx == 8'hb6
		|| idx == 8'hb8 || idx == 8'hbc;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	a_ready_high: assert property (hreadyout)
		else $error("hreadyout low");
	a_resp_okay: assert property (!hresp)
		else $error("hresp not okay");
	a_rdata_hold: assert property (!rdTaken |=> $stable(hrdata))
		else $error("hrdata moved without read");
	a_unmapped_zero: assert property (rdTaken && !mapped |=> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_fifo_codes: assert property (rdTaken && idx == 8'hbc |=> hrdata[7:4] == 4'h0
		&& (!hrdata[0] || hrdata[3:2] != 2'b01)) else $error("reserved status");
	a_live_flags: assert property (rdTaken && idx == 8'hb4 |=> hrdata[31:3] == 0
		&& hrdata[2:1] != 2'b11) else $error("live flags bad");
	a_latch_reserved: assert property (rdTaken && idx == 8'hb6 |=>
		(hrdata & 32'hffff_ff62) == 32'h0000_0000) else $error("latch reserved set");
	a_irq_gated: assert property (rxIrq |-> $past(portSummaryIrqEn))
		else $error("irq without port enable");
endmodule // hrx_receiver_asserts
bind hrx_receiver hrx_receiver_asserts hrx_receiver_asserts_i (.mclk(mclk), .rstn(rstn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .rxBitIn(rxBitIn), .rxBitStb(rxBitStb),
	.portSummaryIrqEn(portSummaryIrqEn), .rxIrq(rxIrq));

// >>> verif/hrx_receiver_tb_top.sv
// Bench for the receive HDLC controller: AHB-Lite master tasks,
// serial source model, one task per scenario.
`timescale 1ns/10ps
module hrx_receiver_tb_top;
	localparam [31:0] CTL = 32'h0000_02c0;
	localparam [31:0] LIV = 32'h0000_02d0;
	localparam [31:0] LAT = 32'h0000_02d8;
	localparam [31:0] IEN = 32'h0000_02e0;
	localparam [31:0] FIF = 32'h0000_02f0;
	logic        mclk, rstn, hsel, hwrite, portSummaryIrqEn;
	logic [31:0] haddr, hwdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	wire         hreadyout, hresp, rxIrq, rxBitIn, rxBitStb;
	wire [31:0]  hrdata;
	wire         hready = hreadyout;
	int          miscompares, total_checks;
	logic [15:0] v;
	logic [7:0]  q[$];
	hrx_receiver #(.PWRUP_CYCLES(16'h0002)) hrx_receiver_i (.mclk(mclk), .rstn(rstn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .rxBitIn(rxBitIn), .rxBitStb(rxBitStb),
		.portSummaryIrqEn(portSummaryIrqEn), .rxIrq(rxIrq));
	hrx_serial_src hrx_serial_src_i (.mclk(mclk), .rxBitIn(rxBitIn), .rxBitStb(rxBitStb));
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task complete_run();
		if (miscompares == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [2:0] sz, input logic [15:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		hsize <= sz;
		@(posedge mclk);
		while (hready !== 1'b1) @(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {16'h0000, d};
		@(posedge mclk);
		while (hready !== 1'b1) @(posedge mclk);
		v = hrdata[15:0];
	endtask
	task wr(input logic [31:0] a, input logic [15:0] d);
		bus(1'b1, a, 3'h2, d);
	endtask
	task rdchk(input string n, input logic [31:0] a, input logic [15:0] e);
		bus(1'b0, a, 3'h2, 16'h0000);
		chk(n, e, v);
	endtask
	task pop(input logic [7:0] b, input logic [2:0] s);
		rdchk("fifo", FIF, {b, 4'h0, s, 1'b1});
	endtask
	task peek();
		bus(1'b0, FIF, 3'h0, 16'h0000); // Lane 0 only, never pops
	endtask
	task t_reset();
		rdchk("ctrl", CTL, 16'h0800);
		rdchk("live", LIV, 16'h0002);
		rdchk("latch", LAT, 16'h0000);
		rdchk("irqen", IEN, 16'h0000);
		rdchk("unmapped", 32'h0000_02c8, 16'h0000);
		wr(LIV, 16'hffff);
		rdchk("live ro", LIV, 16'h0002);
	endtask
	task t_status();
		q = {8'h01, 8'h5a, 8'hc3};
		hrx_serial_src_i.frame(q, 1'b1, 1'b0, 0, 1'b0);
		peek();
		chk("peek", 16'h0003, v & 16'h000f);
		pop(8'h01, 3'h1);
		pop(8'h5a, 3'h0);
		peek();
		chk("peek end", 16'h0009, v & 16'h000f);
		bus(1'b0, FIF + 32'h0000_0001, 3'h0, 16'h0000);
		chk("upper", 16'h00c3, {8'h00, v[15:8]});
		peek();
		chk("valid", 16'h0000, v & 16'h0001);
		rdchk("latch", LAT, 16'h0018);
		wr(LAT, 16'h0018);
		rdchk("latch clr", LAT, 16'h0000);
	endtask
	task t_codes();
		wr(CTL, 16'h080e);
		hrx_serial_src_i.inv = 1'b1;
		q = {8'h01, 8'h02, 8'h03};
		hrx_serial_src_i.frame(q, 1'b0, 1'b0, 0, 1'b1);
		pop(8'h80, 3'h1);
		pop(8'h40, 3'h0);
		pop(8'hc0, 3'h7);
		q = {8'h01, 8'h02};
		hrx_serial_src_i.frame(q, 1'b0, 1'b0, 3, 1'b0);
		// Three spare bits and the flag's head fill one more whole byte; two flag bits remain
		pop(8'h80, 3'h1);
		pop(8'h40, 3'h0);
		pop(8'h0f, 3'h6);
		wr(CTL, 16'h080c);
		hrx_serial_src_i.frame(q, 1'b1, 1'b1, 0, 1'b0);
		pop(8'h80, 3'h1);
		pop(8'h40, 3'h5);
		hrx_serial_src_i.inv = 1'b0;
	endtask
	task t_avail();
		wr(CTL, 16'h0102);
		wr(LAT, 16'h00ff);
		q = {8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
		hrx_serial_src_i.frame(q, 1'b0, 1'b0, 0, 1'b0);
		rdchk("live 7", LIV, 16'h0000);
		q = {8'h07};
		hrx_serial_src_i.frame(q, 1'b0, 1'b0, 0, 1'b0);
		rdchk("live 8", LIV, 16'h0001);
		rdchk("latch", LAT, 16'h0019);
		wr(CTL, 16'h0103);
		rdchk("live flush", LIV, 16'h0002);
		hrx_serial_src_i.frame(q, 1'b0, 1'b0, 0, 1'b0);
		rdchk("discard", LIV, 16'h0002);
		wr(CTL, 16'h0102);
		repeat (4) @(posedge mclk);
	endtask
	task t_irq();
		wr(LAT, 16'h00ff);
		wr(IEN, 16'h0010);
		q = {8'h3c};
		hrx_serial_src_i.frame(q, 1'b0, 1'b0, 0, 1'b0);
		chk("irq port off", 16'h0000, {15'h0000, rxIrq});
		portSummaryIrqEn <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("irq on", 16'h0001, {15'h0000, rxIrq});
		wr(IEN, 16'h0000);
		repeat (3) @(posedge mclk);
		chk("irq own off", 16'h0000, {15'h0000, rxIrq});
		pop(8'h3c, 3'h4);
	endtask
	task t_full();
		wr(CTL, 16'h0802);
		wr(LAT, 16'h00ff);
		q = {};
		for (int i = 0; i < 260; i++)
			q.push_back(i[7:0]);
		hrx_serial_src_i.frame(q, 1'b0, 1'b0, 0, 1'b0);
		rdchk("live full", LIV, 16'h0005);
		rdchk("latch", LAT, 16'h008d);
		pop(8'h00, 3'h1);
		rdchk("live 255", LIV, 16'h0001);
		wr(CTL, 16'h0803);
		peek();
		chk("flush valid", 16'h0000, v & 16'h0001);
	endtask
	initial
	begin
		rstn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		portSummaryIrqEn = 1'b0;
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		repeat (8) @(posedge mclk);
		t_reset();
		t_status();
		t_codes();
		t_avail();
		t_irq();
		t_full();
		complete_run();
	end
	initial
	begin
		#5_000_000;
		miscompares++;
		complete_run();
	end
endmodule // hrx_receiver_tb_top

// >>> verif/hrx_serial_src.sv
// Serial source in place of the framer's overhead path.
// One bit per strobe on mclk; strobe low between frames.
`timescale 1ns/10ps
module hrx_serial_src (
	input  wire  mclk,     // Clock
	output logic rxBitIn,  // Bit
	output logic rxBitStb  // Strobe
);
	logic        inv;
	int          ones;
	logic [15:0] crc;
	initial
	begin
		inv = 1'b0;
		rxBitIn = 1'b0;
		rxBitStb = 1'b0;
	end
	task put(input logic b);
		@(posedge mclk);
		rxBitIn <= b ^ inv;
		rxBitStb <= 1'b1;
	endtask
	task dbit(input logic b);
		put(b);
		ones = b ? ones + 1 : 0;
		if (ones == 5)
		begin
			put(1'b0);
			ones = 0;
		end
	endtask
	task flag();
		for (int i = 0; i < 8; i++)
			put(i != 0 && i != 7);
		ones = 0;
	endtask
	task frame(input logic [7:0] d[$], input logic fcs, input logic bad,
		input int extra, input logic abrt);
		flag();
		crc = 16'hffff;
		foreach (d[k])
			for (int i = 0; i < 8; i++)
			begin
				dbit(d[k][i]);
				crc = {1'b0, crc[15:1]} ^ ((crc[0] ^ d[k][i]) ? 16'h8408 : 16'h0000);
			end
		crc = ~crc ^ {15'h0000, bad};
		for (int i = 0; i < 16 && fcs; i++)
			dbit(crc[i]);
		repeat (extra) dbit(1'b0);
		if (abrt)
			repeat (8) put(1'b1);
		else
			flag();
		@(posedge mclk);
		rxBitStb <= 1'b0;
		rxBitIn <= ~rxBitIn;
		repeat (4) @(posedge mclk);
	endtask
endmodule // hrx_serial_src
